// [rtl/uplink_port.sv]
// Uplink port top: serial register access, strap load, pin directions, link path.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Reduced mode: transmit control, nibble, clock are inputs; receive side outputs.
// - Reduced port carries up to 1000 Mbps, following interface revision 2.0.
// - Control bit 4 enables ingress clock delay, bit 3 egress delay.
// - After reset ingress delay reads 0 and egress delay reads 1.
// - Strap or control bits 1:0 equal to 11 select reduced mode.
// - Speed from strap or control bit 6: 1 gigabit, 0 is 10/100.
// - Nibble mode role, PHY or MAC, is chosen by role strap.
// - PHY role takes transmit signals, drives clocks, collision, carrier, receive.
// - MAC role takes clocks, collision, carrier; drives receive signals to PHY.
// - Nibble data moves four unencoded bits per clock.
// - Each nibble direction carries valid and error beside the data.
// - Half duplex: collision asserts on collision while transmitting.
// - Gigabit reduced clocks run 125 MHz, data on both edges.
// - Control bytes reachable over the serial host interface.
module uplink_port
  import uplink_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       uplink_link_clock,
  input  wire logic [1:0] interface_select_strap,
  input  wire logic       speed_select_strap,
  input  wire logic       role_select_strap,
  input  wire logic       half_duplex,
  input  wire logic       spi_cs_n,
  input  wire logic       spi_clk,
  input  wire logic       spi_mosi,
  output logic            spi_miso,
  output logic            spi_miso_oe_n,
  input  wire logic       uplink_tx_control_in,
  input  wire logic       uplink_tx_error,
  input  wire logic [3:0] uplink_tx_nibble,
  output logic            uplink_tx_clock_o,
  output logic            uplink_tx_clock_oe_n,
  output logic            uplink_rx_control_out,
  output logic            uplink_rx_error,
  output logic      [3:0] uplink_rx_nibble,
  output logic            uplink_rx_clock_o,
  output logic            uplink_rx_clock_oe_n,
  input  wire logic       uplink_collision_i,
  output logic            uplink_collision_o,
  output logic            uplink_collision_oe_n,
  input  wire logic       uplink_carrier_sense_i,
  output logic            uplink_carrier_sense_o,
  output logic            uplink_carrier_sense_oe_n,
  input  wire logic [7:0] egress_data,
  input  wire logic       egress_valid,
  input  wire logic       egress_error,
  output logic      [7:0] ingress_data,
  output logic            ingress_valid,
  output logic            ingress_error,
  output logic            link_byte_wide,
  output logic            partner_collision,
  output logic            partner_carrier,
  output logic            uplink_reduced_gig_mode,
  output logic            ingress_delay_en,
  output logic            egress_delay_en,
  output logic      [2:0] pad_drive_strength
);
  logic [2:0]  spi_s;
  logic [3:0]  strap_s;
  logic        sclk_prev;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_active;
  logic [7:0]  byte_in;
  spi_state_e  spi_state, next_spi_state;
  logic [2:0]  bit_cnt, next_bit_cnt;
  logic [7:0]  rx_shift, next_rx_shift;
  logic [7:0]  tx_shift, next_tx_shift;
  logic [7:0]  spi_addr, next_spi_addr;
  logic        is_read, next_is_read;
  logic        next_miso;
  logic [7:0]  ctrl_reg, next_ctrl_reg;
  logic [7:0]  drive_reg, next_drive_reg;
  logic        strap_done, next_strap_done;
  logic        phy_role, next_phy_role;
  logic        wr_ctrl;
  logic        rgmii;
  logic        mii_phy;

  // Serial pins come from another clock; the serial clock must stay below sys_clk/4.
  uplink_sync2 #(.W(3)) u_spi_sync (
    .clk(sys_clk),
    .d  ({spi_cs_n, spi_clk, spi_mosi}),
    .q  (spi_s)
  );
  uplink_sync2 #(.W(4)) u_strap_sync (
    .clk(sys_clk),
    .d  ({interface_select_strap, speed_select_strap, role_select_strap}),
    .q  (strap_s)
  );

  assign cs_active = !spi_s[2];
  assign sclk_rise = spi_s[1] & !sclk_prev;
  assign sclk_fall = !spi_s[1] & sclk_prev;
  assign byte_in   = {rx_shift[6:0], spi_s[0]};

  function automatic logic [7:0] reg_read(input logic [7:0] addr, input logic [7:0] c,
                                          input logic [7:0] d);
    if (addr == CTRL_ADDR) begin
      reg_read = c;
    end else if (addr == DRIVE_ADDR) begin
      reg_read = d;
    end else begin
      reg_read = 8'h00;
    end
  endfunction

  always_comb begin
    next_spi_state  = spi_state;
    next_bit_cnt    = bit_cnt;
    next_rx_shift   = rx_shift;
    next_tx_shift   = tx_shift;
    next_spi_addr   = spi_addr;
    next_is_read    = is_read;
    next_miso       = spi_miso;
    next_ctrl_reg   = ctrl_reg;
    next_drive_reg  = drive_reg;
    next_strap_done = 1'b1;
    next_phy_role   = phy_role;
    wr_ctrl         = 1'b0;
    if (!cs_active) begin
      next_spi_state = SPI_CMD;
      next_bit_cnt   = 3'h0;
    end else if (sclk_rise) begin
      next_rx_shift = byte_in;
      next_bit_cnt  = bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        case (spi_state)
          SPI_CMD: begin
            if (byte_in == SPI_CMD_READ) begin
              next_is_read   = 1'b1;
              next_spi_state = SPI_ADDR;
            end else if (byte_in == SPI_CMD_WRITE) begin
              next_is_read   = 1'b0;
              next_spi_state = SPI_ADDR;
            end else begin
              next_spi_state = SPI_IGNORE;
            end
          end
          SPI_ADDR: begin
            next_spi_addr  = byte_in;
            next_spi_state = SPI_DATA;
            if (is_read) begin
              next_tx_shift = reg_read(byte_in, ctrl_reg, drive_reg);
            end
          end
          SPI_DATA: begin
            // The address counter wraps from the top address back to zero.
            next_spi_addr = spi_addr + 8'h01;
            if (is_read) begin
              next_tx_shift = reg_read(spi_addr + 8'h01, ctrl_reg, drive_reg);
            end else if (spi_addr == CTRL_ADDR) begin
              next_ctrl_reg = byte_in & CTRL_WMASK;
              wr_ctrl       = 1'b1;
            end else if (spi_addr == DRIVE_ADDR) begin
              next_drive_reg = byte_in;
            end
          end
          default: begin
          end
        endcase
      end
    end else if (sclk_fall && spi_state == SPI_DATA && is_read) begin
      next_miso     = tx_shift[7];
      next_tx_shift = {tx_shift[6:0], 1'b0};
    end
    // Straps are loaded once, in the first cycle after reset release.
    if (!strap_done) begin
      next_ctrl_reg[IF_SEL_MSB:IF_SEL_LSB] = strap_s[3:2];
      next_ctrl_reg[SPEED_BIT]             = strap_s[1];
      next_phy_role                        = strap_s[0];
    end
  end

  always_ff @(posedge sys_clk) begin
    sclk_prev <= spi_s[1];
    if (sys_rst) begin
      spi_state  <= SPI_CMD;
      bit_cnt    <= 3'h0;
      rx_shift   <= 8'h00;
      tx_shift   <= 8'h00;
      spi_addr   <= 8'h00;
      is_read    <= 1'b0;
      spi_miso   <= 1'b0;
      ctrl_reg   <= CTRL_RESET;
      drive_reg  <= DRIVE_RESET;
      strap_done <= 1'b0;
      phy_role   <= 1'b0;
    end else begin
      spi_state  <= next_spi_state;
      bit_cnt    <= next_bit_cnt;
      rx_shift   <= next_rx_shift;
      tx_shift   <= next_tx_shift;
      spi_addr   <= next_spi_addr;
      is_read    <= next_is_read;
      spi_miso   <= next_miso;
      ctrl_reg   <= next_ctrl_reg;
      drive_reg  <= next_drive_reg;
      strap_done <= next_strap_done;
      phy_role   <= next_phy_role;
    end
  end

  assign spi_miso_oe_n = spi_s[2];

  assign rgmii                   = ctrl_reg[IF_SEL_MSB:IF_SEL_LSB] == IF_SEL_REDUCED;
  assign mii_phy                 = !rgmii && phy_role;
  assign uplink_reduced_gig_mode = rgmii;
  // Delay and drive settings go to the pad cells; the partner covers the other half.
  assign ingress_delay_en        = ctrl_reg[INGRESS_DLY_BIT];
  assign egress_delay_en         = ctrl_reg[EGRESS_DLY_BIT];
  assign pad_drive_strength      = drive_reg[DRIVE_MSB:DRIVE_LSB];

  // The transmit clock pin is driven only as a nibble PHY; otherwise it is an input.
  assign uplink_tx_clock_oe_n      = !mii_phy;
  assign uplink_rx_clock_oe_n      = !(rgmii || phy_role);
  assign uplink_collision_oe_n     = !mii_phy;
  assign uplink_carrier_sense_oe_n = !mii_phy;
  assign uplink_tx_clock_o         = uplink_link_clock;
  assign uplink_rx_clock_o         = uplink_link_clock;

  uplink_cfg_if cfg ();
  assign cfg.rgmii_mode  = rgmii;
  assign cfg.gig_speed   = ctrl_reg[SPEED_BIT];
  assign cfg.phy_role    = phy_role;
  assign cfg.half_duplex = half_duplex;

  uplink_link_path u_link (
    .uplink_link_clock     (uplink_link_clock),
    .sys_rst               (sys_rst),
    .cfg                   (cfg.sink),
    .uplink_tx_control_in  (uplink_tx_control_in),
    .uplink_tx_error       (uplink_tx_error),
    .uplink_tx_nibble      (uplink_tx_nibble),
    .uplink_rx_control_out (uplink_rx_control_out),
    .uplink_rx_error       (uplink_rx_error),
    .uplink_rx_nibble      (uplink_rx_nibble),
    .uplink_collision_i    (uplink_collision_i),
    .uplink_collision_o    (uplink_collision_o),
    .uplink_carrier_sense_i(uplink_carrier_sense_i),
    .uplink_carrier_sense_o(uplink_carrier_sense_o),
    .egress_data           (egress_data),
    .egress_valid          (egress_valid),
    .egress_error          (egress_error),
    .ingress_data          (ingress_data),
    .ingress_valid         (ingress_valid),
    .ingress_error         (ingress_error),
    .link_byte_wide        (link_byte_wide),
    .partner_collision     (partner_collision),
    .partner_carrier       (partner_carrier)
  );

  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  reset_delay_a: assert property ($fell(sys_rst) |->
    !ctrl_reg[INGRESS_DLY_BIT] && ctrl_reg[EGRESS_DLY_BIT])
    else $error("delay enables not 0 and 1 after reset");
  strap_load_a: assert property ($fell(sys_rst) |=>
    ctrl_reg[1:0] == $past(strap_s[3:2]) && phy_role == $past(strap_s[0]))
    else $error("straps not loaded after reset");
  delay_write_a: assert property (wr_ctrl |=>
    ingress_delay_en == $past(byte_in[INGRESS_DLY_BIT])
    && egress_delay_en == $past(byte_in[EGRESS_DLY_BIT]))
    else $error("delay enables do not follow control write");
  speed_write_a: assert property (wr_ctrl |=>
    cfg.gig_speed == $past(byte_in[SPEED_BIT])) else $error("speed does not follow write");
  reduced_pins_a: assert property (wr_ctrl && byte_in[1:0] == 2'h3 |=>
    uplink_reduced_gig_mode && uplink_tx_clock_oe_n && !uplink_rx_clock_oe_n
    && uplink_collision_oe_n) else $error("reduced mode pin directions wrong");
  phy_pins_a: assert property (!rgmii && phy_role |->
    !uplink_tx_clock_oe_n && !uplink_rx_clock_oe_n && !uplink_collision_oe_n
    && !uplink_carrier_sense_oe_n) else $error("PHY role not driving clocks and status");
  mac_pins_a: assert property (!rgmii && !phy_role |->
    uplink_tx_clock_oe_n && uplink_rx_clock_oe_n && uplink_carrier_sense_oe_n)
    else $error("MAC role driving an input pin");
  role_hold_a: assert property (strap_done && $past(strap_done) |->
    $stable(phy_role)) else $error("role changed after strap load");
  spi_read_a: assert property (cs_active && sclk_rise && bit_cnt == 3'h7
    && spi_state == SPI_ADDR && is_read |=>
    tx_shift == reg_read($past(byte_in), $past(ctrl_reg), $past(drive_reg)))
    else $error("read data not loaded from addressed register");

  ctrl_write_c: cover property (wr_ctrl);
  ctrl_read_c: cover property (spi_state == SPI_DATA && is_read && spi_addr == CTRL_ADDR);
  mac_role_c: cover property (strap_done && !rgmii && !phy_role);
endmodule // uplink_port
`default_nettype wire

// [shared/uplink_pkg.sv]
// Constants, field positions and types shared by the uplink port design.
`default_nettype none
package uplink_pkg;
  localparam logic [7:0] SPI_CMD_READ    = 8'h03;
  localparam logic [7:0] SPI_CMD_WRITE   = 8'h02;
  localparam logic [7:0] CTRL_ADDR       = 8'h56;
  localparam logic [7:0] DRIVE_ADDR      = 8'ha4;
  localparam int         SPEED_BIT       = 6;
  localparam int         INGRESS_DLY_BIT = 4;
  localparam int         EGRESS_DLY_BIT  = 3;
  localparam int         IF_SEL_MSB      = 1;
  localparam int         IF_SEL_LSB      = 0;
  localparam int         DRIVE_MSB       = 6;
  localparam int         DRIVE_LSB       = 4;
  localparam logic [1:0] IF_SEL_REDUCED  = 2'h3;
  localparam logic [7:0] CTRL_RESET      = 8'h4b;
  localparam logic [7:0] CTRL_WMASK      = 8'hdb;
  localparam logic [7:0] DRIVE_RESET     = 8'h00;
  localparam int         GIG_CLOCK_MHZ   = 125;
  localparam int         SYS_CLOCK_MHZ   = 40;
  typedef enum logic [1:0] {SPI_CMD, SPI_ADDR, SPI_DATA, SPI_IGNORE} spi_state_e;
endpackage
`default_nettype wire

// [shared/uplink_cfg_if.sv]
// Configuration levels handed from the register side to the link side.
`timescale 1ns/100ps
`default_nettype none
interface uplink_cfg_if;
  logic rgmii_mode;
  logic gig_speed;
  logic phy_role;
  logic half_duplex;
  modport source (output rgmii_mode, output gig_speed, output phy_role, output half_duplex);
  modport sink   (input rgmii_mode, input gig_speed, input phy_role, input half_duplex);
endinterface
`default_nettype wire

// [rtl/uplink_sync2.sv]
// Two-flop synchroniser for levels entering a clock domain.
`timescale 1ns/100ps
`default_nettype none
module uplink_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk) begin
    meta <= d;
    q    <= meta;
  end
endmodule // uplink_sync2
`default_nettype wire

// [rtl/uplink_link_path.sv]
// Link-clock side of the uplink port: double-edge and nibble data paths.
`timescale 1ns/100ps
`default_nettype none
module uplink_link_path
  import uplink_pkg::*;
(
  input  wire logic       uplink_link_clock,
  input  wire logic       sys_rst,
  uplink_cfg_if.sink      cfg,
  input  wire logic       uplink_tx_control_in,
  input  wire logic       uplink_tx_error,
  input  wire logic [3:0] uplink_tx_nibble,
  output logic            uplink_rx_control_out,
  output logic            uplink_rx_error,
  output logic      [3:0] uplink_rx_nibble,
  input  wire logic       uplink_collision_i,
  output logic            uplink_collision_o,
  input  wire logic       uplink_carrier_sense_i,
  output logic            uplink_carrier_sense_o,
  input  wire logic [7:0] egress_data,
  input  wire logic       egress_valid,
  input  wire logic       egress_error,
  output logic      [7:0] ingress_data,
  output logic            ingress_valid,
  output logic            ingress_error,
  output logic            link_byte_wide,
  output logic            partner_collision,
  output logic            partner_carrier
);
  logic       link_rst;
  logic [3:0] cfg_s;
  logic [1:0] far_s;
  logic       rgmii, phy, half;
  logic       rise_ctl, next_rise_ctl, fall_ctl_st, next_fall_ctl_st, fall_ctl;
  logic [3:0] rise_nib, next_rise_nib, fall_nib_st, next_fall_nib_st, fall_nib;
  logic       next_rx_error;
  logic       in_rise_ctl, in_rise_err, in_fall_ctl;
  logic [3:0] in_rise_nib, in_fall_nib;
  logic [7:0] next_ingress_data;
  logic       next_ingress_valid, next_ingress_error;
  logic       next_col, next_crs;

  uplink_sync2 #(.W(1)) u_rst (.clk(uplink_link_clock), .d(sys_rst), .q(link_rst));
  uplink_sync2 #(.W(4)) u_cfg (.clk(uplink_link_clock),
    .d({cfg.rgmii_mode, cfg.gig_speed, cfg.phy_role, cfg.half_duplex}), .q(cfg_s));
  uplink_sync2 #(.W(2)) u_far (.clk(uplink_link_clock),
    .d({uplink_collision_i, uplink_carrier_sense_i}), .q(far_s));

  assign rgmii          = cfg_s[3];
  assign link_byte_wide = cfg_s[3] & cfg_s[2];
  assign phy            = cfg_s[1];
  assign half           = cfg_s[0];

  always_comb begin
    // Reduced mode: control carries valid on the rise and valid with error clear on the fall.
    next_rise_ctl      = egress_valid;
    next_rise_nib      = egress_valid ? egress_data[3:0] : 4'h0;
    next_fall_ctl_st   = rgmii ? (egress_valid & ~egress_error) : egress_valid;
    next_fall_nib_st   = !egress_valid ? 4'h0 :
                         (link_byte_wide ? egress_data[7:4] : egress_data[3:0]);
    next_rx_error      = !rgmii & egress_valid & egress_error;
    next_ingress_valid = in_rise_ctl;
    next_ingress_error = rgmii ? (in_rise_ctl ^ in_fall_ctl) : in_rise_err;
    next_ingress_data  = link_byte_wide ? {in_fall_nib, in_rise_nib} : {4'h0, in_rise_nib};
    next_crs           = phy & !rgmii & (egress_valid | uplink_tx_control_in);
    next_col           = next_crs & half & egress_valid & uplink_tx_control_in;
  end

  always_ff @(posedge uplink_link_clock) begin
    if (link_rst) begin
      rise_ctl <= 1'b0; rise_nib <= 4'h0; fall_ctl_st <= 1'b0; fall_nib_st <= 4'h0;
      uplink_rx_error <= 1'b0; in_rise_ctl <= 1'b0; in_rise_err <= 1'b0;
      in_rise_nib <= 4'h0; ingress_data <= 8'h00; ingress_valid <= 1'b0;
      ingress_error <= 1'b0; uplink_collision_o <= 1'b0; uplink_carrier_sense_o <= 1'b0;
      partner_collision <= 1'b0; partner_carrier <= 1'b0;
    end else begin
      rise_ctl <= next_rise_ctl; rise_nib <= next_rise_nib;
      fall_ctl_st <= next_fall_ctl_st; fall_nib_st <= next_fall_nib_st;
      uplink_rx_error <= next_rx_error;
      in_rise_ctl <= uplink_tx_control_in; in_rise_err <= uplink_tx_error;
      in_rise_nib <= uplink_tx_nibble;
      ingress_data <= next_ingress_data; ingress_valid <= next_ingress_valid;
      ingress_error <= next_ingress_error;
      uplink_collision_o <= next_col; uplink_carrier_sense_o <= next_crs;
      partner_collision <= far_s[1]; partner_carrier <= far_s[0];
    end
  end

  // Falling-edge half of the double-data-rate path, used at 125 MHz.
  always_ff @(negedge uplink_link_clock) begin
    if (link_rst) begin
      fall_ctl <= 1'b0; fall_nib <= 4'h0; in_fall_ctl <= 1'b0; in_fall_nib <= 4'h0;
    end else begin
      fall_ctl <= fall_ctl_st; fall_nib <= fall_nib_st;
      in_fall_ctl <= uplink_tx_control_in; in_fall_nib <= uplink_tx_nibble;
    end
  end

  // The output mux stands in for a pad DDR cell; in nibble modes both halves match.
  assign uplink_rx_control_out = uplink_link_clock ? rise_ctl : fall_ctl;
  assign uplink_rx_nibble      = uplink_link_clock ? rise_nib : fall_nib;

  default clocking @(posedge uplink_link_clock); endclocking
  default disable iff (link_rst);
  idle_low_a: assert property (!egress_valid |=> !rise_ctl && rise_nib == 4'h0
    && !fall_ctl_st) else $error("egress control or data not low while idle");
  ddr_byte_a: assert property (link_byte_wide && egress_valid |=>
    rise_nib == $past(egress_data[3:0]) && fall_nib_st == $past(egress_data[7:4]))
    else $error("byte not split low nibble first");
  nibble_in_a: assert property (!rgmii |=> rgmii || (ingress_valid == $past(in_rise_ctl)
    && ingress_error == $past(in_rise_err))) else $error("nibble ingress flags wrong");
  nibble_width_a: assert property (!rgmii ##1 !rgmii |=> ingress_data[7:4] == 4'h0)
    else $error("upper nibble set in nibble mode");
  collision_a: assert property (phy && !rgmii && half && egress_valid
    && uplink_tx_control_in |=> uplink_collision_o) else $error("collision missed");
  byte_frame_c: cover property (link_byte_wide && egress_valid [*4]);
endmodule // uplink_link_path
`default_nettype wire

// [verification/uplink_partner.sv]
// Far-side link partner: link clock and ingress pin driver.
`timescale 1ns/100ps
`default_nettype none
module uplink_partner (
  output logic       uplink_link_clock,
  output logic       uplink_tx_control_in,
  output logic       uplink_tx_error,
  output logic [3:0] uplink_tx_nibble
);
  // Link clocks run free, so the clock keeps toggling between frames.
  initial begin
    uplink_link_clock = 1'b0;
    uplink_tx_control_in = 1'b0;
    uplink_tx_error = 1'b0;
    uplink_tx_nibble = 4'h0;
    #7;
    forever #24 uplink_link_clock = ~uplink_link_clock;
  end
  // Rise data is set before the rising edge, fall data before the falling one.
  task automatic beat(input logic cr, input logic [3:0] nr, input logic cf, input logic [3:0] nf);
    @(negedge uplink_link_clock) #2;
    uplink_tx_control_in = cr;
    uplink_tx_nibble = nr;
    // Data moves just after the opposite edge, so each sampling edge sits 2 ns before the data moves again.
    // This is the clock delay the partner must add while the port's ingress delay is off.
    @(posedge uplink_link_clock) #2;
    uplink_tx_control_in = cf;
    uplink_tx_nibble = nf;
  endtask
  // Released data shows the inverse of the last nibble, so a stale copy is never read.
  task automatic idle;
    @(negedge uplink_link_clock) #2;
    uplink_tx_control_in = 1'b0;
    uplink_tx_nibble = ~uplink_tx_nibble;
  endtask
endmodule // uplink_partner
`default_nettype wire

// [verification/uplink_port_test.sv]
// Self-checking bench for the uplink port: registers, reduced and nibble paths.
`timescale 1ns/100ps
`default_nettype none
module uplink_port_test;
  import uplink_pkg::*;
  logic sys_clk, sys_rst, spi_cs_n, spi_clk, spi_mosi, spi_miso, spi_miso_oe_n;
  logic role_select_strap, speed_select_strap, half_duplex, egress_valid, egress_error;
  logic uplink_collision_i, uplink_carrier_sense_i, uplink_link_clock, uplink_tx_control_in;
  logic uplink_tx_error, uplink_tx_clock_o, uplink_tx_clock_oe_n, uplink_rx_control_out;
  logic uplink_rx_error, uplink_rx_clock_o, uplink_rx_clock_oe_n, uplink_collision_o;
  logic uplink_collision_oe_n, uplink_carrier_sense_o, uplink_carrier_sense_oe_n;
  logic ingress_valid, ingress_error, link_byte_wide, partner_collision, partner_carrier;
  logic uplink_reduced_gig_mode, ingress_delay_en, egress_delay_en;
  logic [1:0] interface_select_strap;
  logic [2:0] pad_drive_strength;
  logic [3:0] uplink_tx_nibble, uplink_rx_nibble;
  logic [7:0] egress_data, ingress_data, rd;
  int fail_count, checks;
  uplink_port u_uplink_port (
    .sys_clk, .sys_rst, .uplink_link_clock, .interface_select_strap, .speed_select_strap,
    .role_select_strap, .half_duplex, .spi_cs_n, .spi_clk, .spi_mosi, .spi_miso,
    .spi_miso_oe_n, .uplink_tx_control_in, .uplink_tx_error, .uplink_tx_nibble,
    .uplink_tx_clock_o, .uplink_tx_clock_oe_n, .uplink_rx_control_out, .uplink_rx_error,
    .uplink_rx_nibble, .uplink_rx_clock_o, .uplink_rx_clock_oe_n, .uplink_collision_i,
    .uplink_collision_o, .uplink_collision_oe_n, .uplink_carrier_sense_i,
    .uplink_carrier_sense_o, .uplink_carrier_sense_oe_n, .egress_data, .egress_valid,
    .egress_error, .ingress_data, .ingress_valid, .ingress_error, .link_byte_wide,
    .partner_collision, .partner_carrier, .uplink_reduced_gig_mode, .ingress_delay_en,
    .egress_delay_en, .pad_drive_strength);
  uplink_partner u_uplink_partner (.uplink_link_clock, .uplink_tx_control_in,
    .uplink_tx_error, .uplink_tx_nibble);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // A twin port across the link takes each delay that the opposite direction leaves out.
  function automatic logic [1:0] twin_delay(input logic ingress, input logic egress);
    twin_delay = {~egress, ~ingress};
  endfunction
  task automatic lstep;
    @(posedge uplink_link_clock) #2;
  endtask
  // Serial clock stays well under a quarter of sys_clk so every edge is synchronised.
  task automatic spi(input logic [23:0] sh, output logic [7:0] r);
    r = 8'h00;
    spi_cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      spi_mosi = sh[i];
      repeat (6) @(posedge sys_clk);
      #2 spi_clk = 1'b1;
      r = {r[6:0], spi_miso};
      repeat (6) @(posedge sys_clk);
      #2 spi_clk = 1'b0;
    end
    repeat (6) @(posedge sys_clk);
    #2 spi_cs_n = 1'b1;
    repeat (8) @(posedge sys_clk);
    #2;
  endtask
  // Reset is held long enough for both domains to see it.
  task automatic reset_dut(input logic [1:0] sel, input logic spd, input logic role);
    @(posedge sys_clk) #2;
    sys_rst = 1'b1;
    interface_select_strap = sel;
    speed_select_strap = spd;
    role_select_strap = role;
    repeat (10) @(posedge sys_clk);
    #2 sys_rst = 1'b0;
    repeat (8) @(posedge sys_clk);
    #2;
  endtask
  task automatic t_regs;
    spi({SPI_CMD_READ, CTRL_ADDR, 8'h00}, rd);
    check(rd, 8'h4b);
    check(ingress_delay_en, 1'b0);
    check(egress_delay_en, 1'b1);
    check(twin_delay(ingress_delay_en, egress_delay_en), 8'h01);
    check(uplink_reduced_gig_mode, 1'b1);
    check(link_byte_wide, 1'b1);
    spi({SPI_CMD_READ, 8'h10, 8'h00}, rd);
    check(rd, 8'h00);
    for (int k = 0; k < 4; k++) begin
      spi({SPI_CMD_WRITE, CTRL_ADDR, 8'h43 | 8'(k << 3)}, rd);
      check(ingress_delay_en, k[1]);
      check(egress_delay_en, k[0]);
    end
    check(twin_delay(ingress_delay_en, egress_delay_en), 8'h00);
    spi({SPI_CMD_WRITE, DRIVE_ADDR, 8'h50}, rd);
    check(pad_drive_strength, 8'h05);
    spi({SPI_CMD_WRITE, CTRL_ADDR, 8'hff}, rd);
    spi({SPI_CMD_READ, CTRL_ADDR, 8'h00}, rd);
    check(rd, 8'hdb);
    spi({SPI_CMD_WRITE, CTRL_ADDR, 8'h0b}, rd);
    check(link_byte_wide, 1'b0);
    spi({SPI_CMD_WRITE, CTRL_ADDR, 8'h48}, rd);
    check(uplink_reduced_gig_mode, 1'b0);
    spi({SPI_CMD_WRITE, CTRL_ADDR, 8'h4b}, rd);
  endtask
  task automatic t_reduced;
    check(uplink_rx_clock_oe_n, 1'b0);
    check(uplink_tx_clock_oe_n, 1'b1);
    lstep;
    egress_data = 8'ha5;
    egress_valid = 1'b1;
    lstep;
    egress_valid = 1'b0;
    check(uplink_rx_control_out, 1'b1);
    check(uplink_rx_nibble, 4'h5);
    @(negedge uplink_link_clock) #2;
    check(uplink_rx_nibble, 4'ha);
    lstep;
    check(uplink_rx_control_out, 1'b0);
    u_uplink_partner.beat(1'b1, 4'h3, 1'b1, 4'hc);
    u_uplink_partner.idle;
    lstep;
    check(ingress_data, 8'hc3);
    check(ingress_valid, 1'b1);
    check(ingress_error, 1'b0);
  endtask
  task automatic t_phy;
    reset_dut(2'b00, 1'b1, 1'b1);
    check(uplink_reduced_gig_mode, 1'b0);
    check(uplink_tx_clock_oe_n, 1'b0);
    check(uplink_collision_oe_n, 1'b0);
    check(uplink_carrier_sense_oe_n, 1'b0);
    half_duplex = 1'b1;
    egress_data = 8'hfc;
    egress_valid = 1'b1;
    egress_error = 1'b1;
    lstep;
    check(uplink_rx_nibble, 4'hc);
    check(uplink_rx_error, 1'b1);
    // As external MAC the partner sends clean nibbles and never reads the receive error.
    u_uplink_partner.beat(1'b1, 4'h9, 1'b1, 4'h9);
    lstep;
    check(ingress_data, 8'h09);
    for (int i = 0; i < 16 && uplink_collision_o !== 1'b1; i++) lstep;
    check(uplink_collision_o, 1'b1);
    check(uplink_carrier_sense_o, 1'b1);
    egress_valid = 1'b0;
    u_uplink_partner.idle;
    lstep;
    check(uplink_rx_control_out, 1'b0);
  endtask
  task automatic t_mac;
    reset_dut(2'b01, 1'b1, 1'b0);
    check(uplink_collision_oe_n, 1'b1);
    check(uplink_rx_clock_oe_n, 1'b1);
    uplink_collision_i = 1'b1;
    uplink_carrier_sense_i = 1'b1;
    for (int i = 0; i < 16 && partner_collision !== 1'b1; i++) lstep;
    check(partner_collision, 1'b1);
    check(partner_carrier, 1'b1);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    {sys_rst, spi_cs_n, spi_clk, spi_mosi, half_duplex} = 5'h18;
    {uplink_collision_i, uplink_carrier_sense_i, egress_valid, egress_error} = 4'h0;
    {interface_select_strap, speed_select_strap, role_select_strap} = 4'he;
    egress_data = 8'h00;
    fail_count = 0;
    checks = 0;
    reset_dut(2'b11, 1'b1, 1'b0);
    t_regs;
    t_reduced;
    t_phy;
    t_mac;
    end_sim;
  end
  initial begin
    #2000000;
    fail_count++;
    end_sim;
  end
endmodule // uplink_port_test
`default_nettype wire
